// ===== core/cdcsf_cfg.svh
`ifndef CDCSF_CFG_SVH
`define CDCSF_CFG_SVH
// register offsets (byte addresses, word aligned except ERRCFG at 8'h19)
`define CDCSF_OFS_STATUS   8'h18
`define CDCSF_OFS_ERRCFG   8'h19
`define CDCSF_OFS_RDEVT    8'h1C
`define CDCSF_OFS_IRQ_STAT 8'h20
`define CDCSF_OFS_IRQ_MASK 8'h24
`define CDCSF_OFS_CTRL     8'h28
// status word fields
`define CDCSF_B_CHAN_HI    15
`define CDCSF_B_CHAN_LO    14
`define CDCSF_B_WD         11
`define CDCSF_B_AHW        10
`define CDCSF_B_ALW        9
`define CDCSF_B_CONVERSION_READY_FLAG       6
`define CDCSF_B_UNREAD_HI  3
// error configuration fields
`define CDCSF_B_WD2INT     5
`define CDCSF_B_DRDY2INT   0
// control register fields
`define CDCSF_B_SEQ        0
`define CDCSF_B_ACT_LO     1
`define CDCSF_B_ACT_HI     2
`define CDCSF_B_MULTI_LO   3
`define CDCSF_B_MULTI_HI   4
// irq status bits
`define CDCSF_IRQ_WD       0
`define CDCSF_IRQ_CONVERSION_READY_FLAG     1
`define CDCSF_IRQ_W        2
// reset values
`define CDCSF_RST_STATUS   16'h0000
`define CDCSF_RST_ERRCFG   16'h0000
`define CDCSF_RST_CTRL     16'h0000
`define CDCSF_RST_IRQ      2'h0
`define CDCSF_RST_CHAN     2'h0
`define CDCSF_UNMAPPED     32'h0000_0000
`endif

// ===== core/cdcsf_pkg.sv
package cdcsf_pkg;
  // per-channel events from the conversion core
  typedef struct packed {
    logic [3:0] timeout;
    logic [3:0] amp_high;
    logic [3:0] amp_low;
    logic [3:0] result_new;
  } cdcsf_evt_t;
  // avalon-mm slave request
  typedef struct packed {
    logic [7:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } cdcsf_avm_req_t;
  typedef enum logic [2:0] {
    CDCSF_IDLE = 3'b001,
    CDCSF_ACK  = 3'b010,
    CDCSF_WAIT = 3'b100
  } cdcsf_bus_state_t;
endpackage

// ===== core/cdcsf_status_regs.sv
// The Avalon-MM slave port is this design's own decision.
`timescale 1ns/1ns
`include "cdcsf_cfg.svh"
// Functional notes
// - bits 15:14 name latest fault channel
// - errors latched until status or source read
// - bit 11 flags watchdog timeout
// - bit 10 flags amplitude high warning
// - bit 9 flags amplitude low warning
// - single channel: ready after one result
// - sequential: ready after all active channels
// - bits 3,2 pending result channels 0,1
// - bit 1 pending channel 2, four-channel
// - status read-only, zero after reset
// - bit 0 pending channel 3, four-channel
// - timeouts recorded only when routing enabled
// - ready reported only when routing enabled
module cdcsf_status_regs
#(
  parameter int N_CH = 4
)
(
  // clock, enable, reset
  input  wire logic                    ref_clk,
  input  wire logic                    clk_en,
  input  wire logic                    rst_n,
  // conversion core events, same clock
  input  wire cdcsf_pkg::cdcsf_evt_t   core_evt,
  // result register reads by the host, one bit per channel
  input  wire logic [3:0]              result_read,
  // avalon-mm slave
  input  wire cdcsf_pkg::cdcsf_avm_req_t avs_req,
  output logic [31:0]                  avs_readdata,
  output logic                         avs_waitrequest,
  // interrupt pin and status
  output logic                         interrupt_out_n,
  output logic                         irq
);
  import cdcsf_pkg::*;

  // ****************************************
  // reset release
  // ****************************************
  // assert at once, release through two flops to stay clear of the edge
  logic rst_s1_reg;
  logic rst_s2_reg;
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_s1_reg <= 1'b0;
      rst_s2_reg <= 1'b0;
    end
    else
    begin
      rst_s1_reg <= 1'b1;
      rst_s2_reg <= rst_s1_reg;
    end
  end
  logic srst_n;
  assign srst_n = rst_s2_reg;

  // ****************************************
  // bus handshake: one wait cycle, then ack
  // ****************************************
  cdcsf_bus_state_t bus_reg;
  cdcsf_bus_state_t bus_next;
  logic             req;
  logic             acc;
  assign req = avs_req.read | avs_req.write;
  always_comb
  begin
    bus_next = bus_reg;
    // WAIT holds until the request drops: one idle cycle between requests
    case (bus_reg)
      CDCSF_IDLE: if (req) bus_next = CDCSF_ACK;
      CDCSF_ACK:  bus_next = CDCSF_WAIT;
      CDCSF_WAIT: if (!req) bus_next = CDCSF_IDLE;
      default:    bus_next = CDCSF_IDLE;
    endcase
  end
  // waitrequest low for exactly one cycle per request; held high while
  // frozen, so the master never sees an ack for a write not taken
  assign avs_waitrequest = !acc;
  assign acc = (bus_reg == CDCSF_ACK) && clk_en;

  logic wr_acc;
  logic status_rd;
  assign wr_acc = acc && avs_req.write;
  assign status_rd = acc && avs_req.read
                     && avs_req.address == `CDCSF_OFS_STATUS;

  // ****************************************
  // software registers
  // ****************************************
  logic [15:0] errcfg_reg;
  logic [15:0] errcfg_next;
  logic [15:0] ctrl_reg;
  logic [15:0] ctrl_next;
  logic [1:0]  mask_reg;
  logic [1:0]  mask_next;
  always_comb
  begin
    errcfg_next = errcfg_reg;
    ctrl_next = ctrl_reg;
    mask_next = mask_reg;
    // half-word writes only: a partial write would leave a torn field
    if (wr_acc && avs_req.byteenable[0] && avs_req.byteenable[1])
    begin
      case (avs_req.address)
        `CDCSF_OFS_ERRCFG:   errcfg_next = avs_req.writedata[15:0];
        `CDCSF_OFS_CTRL:     ctrl_next = avs_req.writedata[15:0];
        `CDCSF_OFS_IRQ_MASK:
          mask_next = avs_req.writedata[`CDCSF_IRQ_W-1:0];
        default:             ;
      endcase
    end
  end

  logic       seq_mode;
  logic [1:0] act_ch;
  logic [1:0] multi_last;
  logic       wd2int;
  logic       drdy2int;
  assign seq_mode   = ctrl_reg[`CDCSF_B_SEQ];
  assign act_ch     = ctrl_reg[`CDCSF_B_ACT_HI:`CDCSF_B_ACT_LO];
  assign multi_last = ctrl_reg[`CDCSF_B_MULTI_HI:`CDCSF_B_MULTI_LO];
  assign wd2int     = errcfg_reg[`CDCSF_B_WD2INT];
  assign drdy2int   = errcfg_reg[`CDCSF_B_DRDY2INT];

  // ****************************************
  // status flags
  // ****************************************
  logic [N_CH-1:0] unread_reg;
  logic [N_CH-1:0] unread_next;
  logic [N_CH-1:0] seen_reg;
  logic [N_CH-1:0] seen_next;
  logic [N_CH-1:0] active;
  logic [1:0]      chan_reg;
  logic [1:0]      chan_next;
  logic            wd_reg;
  logic            wd_next;
  logic            ah_reg;
  logic            ah_next;
  logic            al_reg;
  logic            al_next;
  logic            conversion_ready_flag_reg;
  logic            conversion_ready_flag_next;
  logic            src_rd;
  logic [3:0]      any_err;
  logic            conversion_ready_flag_evt;
  // read data flop; it also holds the status snapshot that a read clears
  logic [31:0]     rdata_reg;
  logic [31:0]     rdata_next;

  // ****************************************
  // pending results per channel
  // ****************************************
  genvar g;
  generate
    for (g = 0; g < N_CH; g = g + 1)
    begin : g_ch
      // sequential mode runs channels 0..multi_last
      assign active[g] = seq_mode ? (2'(g) <= multi_last)
                                  : (2'(g) == act_ch);
      // inactive channels never raise a pending bit
      // a new result wins over a same-cycle read
      always_comb
      begin
        unread_next[g] = unread_reg[g];
        if (result_read[g]) unread_next[g] = 1'b0;
        if (core_evt.result_new[g] && active[g])
          unread_next[g] = 1'b1;
      end
    end
  endgenerate

  // ****************************************
  // fault source and ready tracking
  // ****************************************
  // amplitude warnings have no routing enable, so they always count
  assign any_err = (core_evt.timeout & {4{wd2int}})
                 | core_evt.amp_high | core_evt.amp_low;

  always_comb
  begin
    // a channel reporting twice in one sweep still counts once
    seen_next = seen_reg | (core_evt.result_new[N_CH-1:0] & active);
    conversion_ready_flag_evt  = 1'b0;
    if (!seq_mode)
      conversion_ready_flag_evt = |(core_evt.result_new[N_CH-1:0] & active);
    else if ((seen_next & active) == active)
    begin
      conversion_ready_flag_evt  = 1'b1;
      seen_next = '0;
    end
    if (!seq_mode) seen_next = '0;
  end

  // ****************************************
  // error and ready latches
  // ****************************************
  assign src_rd = result_read[chan_reg];

  always_comb
  begin
    wd_next = wd_reg;
    ah_next = ah_reg;
    al_next = al_reg;
    conversion_ready_flag_next = conversion_ready_flag_reg;
    chan_next = chan_reg;
    // a status read clears only what its snapshot showed: a flag set
    // while the snapshot was taken survives for the next read
    if (status_rd)
    begin
      wd_next   = wd_reg && !rdata_reg[`CDCSF_B_WD];
      ah_next   = ah_reg && !rdata_reg[`CDCSF_B_AHW];
      al_next   = al_reg && !rdata_reg[`CDCSF_B_ALW];
      conversion_ready_flag_next = conversion_ready_flag_reg && !rdata_reg[`CDCSF_B_CONVERSION_READY_FLAG];
    end
    // reading the source channel's result releases the error latches
    if (src_rd)
    begin
      wd_next = 1'b0;
      ah_next = 1'b0;
      al_next = 1'b0;
    end
    // events set after the clear so none is lost
    if (|(core_evt.timeout & {4{wd2int}})) wd_next = 1'b1;
    if (|core_evt.amp_high) ah_next = 1'b1;
    if (|core_evt.amp_low) al_next = 1'b1;
    if (conversion_ready_flag_evt && drdy2int) conversion_ready_flag_next = 1'b1;
    // highest channel wins when several fault together
    for (int i = 0; i < 4; i++)
      if (any_err[i]) chan_next = 2'(i);
  end

  // ****************************************
  // interrupt status and mask
  // ****************************************
  logic [1:0] irqst_reg;
  logic [1:0] irqst_next;
  logic [1:0] irq_evt;
  always_comb
  begin
    irq_evt = '0;
    irq_evt[`CDCSF_IRQ_WD] = |(core_evt.timeout & {4{wd2int}});
    irq_evt[`CDCSF_IRQ_CONVERSION_READY_FLAG] = conversion_ready_flag_evt && drdy2int;
    irqst_next = irqst_reg;
    if (wr_acc && avs_req.address == `CDCSF_OFS_IRQ_STAT)
      irqst_next = irqst_reg & ~avs_req.writedata[`CDCSF_IRQ_W-1:0];
    // an event in the clearing cycle wins over the clear
    irqst_next = irqst_next | irq_evt;
  end

  always_ff @(posedge ref_clk or negedge srst_n)
  begin
    if (!srst_n)
    begin
      bus_reg    <= CDCSF_IDLE;
      errcfg_reg <= `CDCSF_RST_ERRCFG;
      ctrl_reg   <= `CDCSF_RST_CTRL;
      mask_reg   <= `CDCSF_RST_IRQ;
      irqst_reg  <= `CDCSF_RST_IRQ;
      unread_reg <= '0;
      seen_reg   <= '0;
      chan_reg   <= `CDCSF_RST_CHAN;
      wd_reg     <= 1'b0;
      ah_reg     <= 1'b0;
      al_reg     <= 1'b0;
      conversion_ready_flag_reg   <= 1'b0;
    end
    // clk_en low freezes every flop but the reset release pair, bus handshake included
    else if (clk_en)
    begin
      bus_reg    <= bus_next;
      errcfg_reg <= errcfg_next;
      ctrl_reg   <= ctrl_next;
      mask_reg   <= mask_next;
      irqst_reg  <= irqst_next;
      unread_reg <= unread_next;
      seen_reg   <= seen_next;
      chan_reg   <= chan_next;
      wd_reg     <= wd_next;
      ah_reg     <= ah_next;
      al_reg     <= al_next;
      conversion_ready_flag_reg   <= conversion_ready_flag_next;
    end
  end

  // ****************************************
  // read path
  // ****************************************
  logic [15:0] status_word;
  always_comb
  begin
    // reserved positions keep the zero base value
    status_word = `CDCSF_RST_STATUS;
    status_word[`CDCSF_B_CHAN_HI:`CDCSF_B_CHAN_LO] = chan_reg;
    status_word[`CDCSF_B_WD] = wd_reg;
    status_word[`CDCSF_B_AHW] = ah_reg;
    status_word[`CDCSF_B_ALW] = al_reg;
    status_word[`CDCSF_B_CONVERSION_READY_FLAG] = conversion_ready_flag_reg;
    // channel 0 at the top bit, descending
    for (int i = 0; i < N_CH; i++)
      status_word[`CDCSF_B_UNREAD_HI - i] = unread_reg[i];
  end

  // data output from a flop, valid in the ack cycle
  // unmapped offsets read as zero
  always_comb
  begin
    rdata_next = `CDCSF_UNMAPPED;
    if (bus_reg == CDCSF_IDLE && avs_req.read)
    begin
      case (avs_req.address)
        `CDCSF_OFS_STATUS:   rdata_next = {16'h0000, status_word};
        `CDCSF_OFS_ERRCFG:   rdata_next = {16'h0000, errcfg_reg};
        `CDCSF_OFS_CTRL:     rdata_next = {16'h0000, ctrl_reg};
        `CDCSF_OFS_IRQ_STAT: rdata_next = {30'h0, irqst_reg};
        `CDCSF_OFS_IRQ_MASK: rdata_next = {30'h0, mask_reg};
        default:             rdata_next = `CDCSF_UNMAPPED;
      endcase
    end
    else if (bus_reg == CDCSF_ACK)
      rdata_next = rdata_reg;
  end
  always_ff @(posedge ref_clk or negedge srst_n)
  begin
    if (!srst_n)
      rdata_reg <= `CDCSF_UNMAPPED;
    else if (clk_en)
      rdata_reg <= rdata_next;
  end
  assign avs_readdata = rdata_reg;

  // ****************************************
  // interrupt outputs
  // ****************************************
  // pin follows the routed event latches; the irq line is masked instead
  assign irq = |(irqst_reg & mask_reg);
  assign interrupt_out_n = !((wd_reg && wd2int)
                             || (conversion_ready_flag_reg && drdy2int));
endmodule

// ===== verif/cdcsf_status_sva.sv
`timescale 1ns/1ns
module cdcsf_status_sva
#(
  parameter int N_CH = 4
)
(
  // clock, enable, reset
  input wire logic                      ref_clk,
  input wire logic                      clk_en,
  input wire logic                      rst_n,
  // core events and result reads
  input wire cdcsf_pkg::cdcsf_evt_t     core_evt,
  input wire logic [3:0]                result_read,
  // avalon-mm slave
  input wire cdcsf_pkg::cdcsf_avm_req_t avs_req,
  input wire logic [31:0]               avs_readdata,
  input wire logic                      avs_waitrequest,
  // interrupt pins
  input wire logic                      interrupt_out_n,
  input wire logic                      irq
);
  import cdcsf_pkg::*;
  // ****************
  // routing enables
  // ****************
  logic wd_en_reg;
  logic rdy_en_reg;
  logic cfg_ack;
  logic st_ack;
  assign cfg_ack = avs_req.write && !avs_waitrequest &&
                   avs_req.address == 8'h19 && avs_req.byteenable[1:0] == 2'h3;
  assign st_ack = avs_req.read && !avs_waitrequest && avs_req.address == 8'h18;
  // tracked from the bus, as the enables sit outside these ports
  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
    begin
      wd_en_reg  <= 1'b0;
      rdy_en_reg <= 1'b0;
    end
    else if (cfg_ack)
    begin
      wd_en_reg  <= avs_req.writedata[5];
      rdy_en_reg <= avs_req.writedata[0];
    end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // ****************
  // properties
  // ****************
  a_ack_one_cycle: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("ack longer than one cycle");
  a_ack_follows_req: assert property (
    $rose(avs_req.read || avs_req.write) |=> !avs_waitrequest)
    else $error("request not answered in one cycle");
  a_no_spurious_ack: assert property (
    !avs_waitrequest |-> avs_req.read || avs_req.write)
    else $error("ack without request");
  a_status_rsv_zero: assert property (st_ack |->
    avs_readdata[31:16] == 16'h0 && avs_readdata[13:12] == 2'h0 &&
    avs_readdata[8:7] == 2'h0 && avs_readdata[5:4] == 2'h0)
    else $error("reserved status bits set");
  a_unmapped_zero: assert property (avs_req.read && !avs_waitrequest &&
    avs_req.address == 8'h1C |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  a_timeout_pin_low: assert property (
    (|core_evt.timeout) && wd_en_reg && clk_en |-> ##[1:2] !interrupt_out_n)
    else $error("enabled timeout did not pull pin low");
  a_routing_off_quiet: assert property (
    !wd_en_reg && !rdy_en_reg && interrupt_out_n |=> interrupt_out_n)
    else $error("pin low with routing off");
  a_read_clears_pin: assert property (
    st_ack && core_evt == '0 && $past(core_evt) == '0 |-> ##2 interrupt_out_n)
    else $error("status read left pin low");
  c_status_read: cover property (st_ack);
  c_timeout_on: cover property ((|core_evt.timeout) && wd_en_reg);
  c_irq_rise: cover property ($rose(irq));
endmodule
bind cdcsf_status_regs cdcsf_status_sva #(.N_CH(N_CH)) chk_u (
  .ref_clk(ref_clk), .clk_en(clk_en), .rst_n(rst_n), .core_evt(core_evt),
  .result_read(result_read), .avs_req(avs_req), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .interrupt_out_n(interrupt_out_n),
  .irq(irq));

// ===== verif/cdcsf_host_model.sv
`timescale 1ns/1ns
module cdcsf_host_model
(
  // clock
  input  wire logic                      ref_clk,
  // command from the bench
  input  wire logic                      go,
  input  wire cdcsf_pkg::cdcsf_avm_req_t cmd,
  output logic                           busy,
  output logic [31:0]                    rdata,
  // avalon-mm master
  output cdcsf_pkg::cdcsf_avm_req_t      avs_req,
  input  wire logic [31:0]               avs_readdata,
  input  wire logic                      avs_waitrequest
);
  import cdcsf_pkg::*;
  initial
  begin
    avs_req = '0;
    busy    = 1'b0;
    rdata   = 32'h0;
  end
  // request held until the edge that sees waitrequest low
  always @(posedge ref_clk)
    if (go)
    begin
      avs_req <= cmd;
      busy    <= 1'b1;
    end
    else if (busy && !avs_waitrequest)
    begin
      rdata             <= avs_readdata;
      avs_req.read      <= 1'b0;
      avs_req.write     <= 1'b0;
      // released lines show the inverse, not a stale copy
      avs_req.address   <= ~avs_req.address;
      avs_req.writedata <= ~avs_req.writedata;
      busy              <= 1'b0;
    end
endmodule

// ===== verif/testbench.sv
`timescale 1ns/1ns
module testbench;
  import cdcsf_pkg::*;
  logic           ref_clk;
  logic           rst_n;
  logic           go;
  logic           busy;
  logic           int_n;
  logic           irq;
  logic [31:0]    rdata;
  logic [31:0]    rd_w;
  logic [3:0]     result_read;
  cdcsf_evt_t     core_evt;
  cdcsf_avm_req_t cmd;
  cdcsf_avm_req_t req;
  int             err_count = 0;
  int             checks_done = 0;
  int             cyc = 0;
  logic           wait_w;
  logic           clk_en;
  cdcsf_status_regs #(.N_CH(4)) dut_u (.ref_clk(ref_clk), .clk_en(clk_en),
    .rst_n(rst_n), .core_evt(core_evt), .result_read(result_read),
    .avs_req(req), .avs_readdata(rd_w), .avs_waitrequest(wait_w),
    .interrupt_out_n(int_n), .irq(irq));
  cdcsf_host_model host_u (.ref_clk(ref_clk), .go(go), .cmd(cmd),
    .busy(busy), .rdata(rdata), .avs_req(req), .avs_readdata(rd_w),
    .avs_waitrequest(wait_w));
  initial
  begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  // ****************
  // tasks
  // ****************
  task automatic final_report;
    if (err_count == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic cmpw(input logic [7:0] a, input logic [31:0] e,
                      input logic [31:0] s);
    checks_done++;
    if (s !== e)
    begin
      err_count++;
      $display("unexpected reg %h exp %h got %h", a, e, s);
    end
  endtask
  task automatic cmpp(input string n, input logic e, input logic s);
    checks_done++;
    if (s !== e)
    begin
      err_count++;
      $display("unexpected %s exp %b got %b", n, e, s);
    end
  endtask
  task automatic xfer(input logic r, input logic [7:0] a,
                      input logic [31:0] d);
    @(posedge ref_clk);
    cmd <= '{a, r, !r, d, 4'hF};
    go  <= 1'b1;
    @(posedge ref_clk);
    go  <= 1'b0;
    do @(negedge ref_clk); while (busy);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b1, a, 32'h0);
    cmpw(a, e, rdata);
  endtask
  task automatic ev(input logic [15:0] e, input logic [3:0] rr);
    @(posedge ref_clk);
    core_evt    <= e;
    result_read <= rr;
    @(posedge ref_clk);
    core_evt    <= '0;
    result_read <= 4'h0;
  endtask
  task automatic pins(input logic en, input logic eq);
    @(posedge ref_clk);
    @(negedge ref_clk);
    cmpp("interrupt_out_n", en, int_n);
    cmpp("irq", eq, irq);
  endtask
  always @(posedge ref_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      err_count++;
      final_report;
    end
  end
  // ****************
  // sequence
  // ****************
  initial
  begin
    rst_n = 1'b0;
    go = 1'b0;
    clk_en = 1'b1;
    cmd = '0;
    core_evt = '0;
    result_read = 4'h0;
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    rdc(8'h18, 32'h0);
    rdc(8'h1C, 32'h0);
    xfer(1'b0, 8'h18, 32'hFFFF);
    rdc(8'h18, 32'h0);
    ev(16'h0001, 4'h0);
    pins(1'b1, 1'b0);
    rdc(8'h18, 32'h0008);
    ev(16'h0000, 4'h1);
    rdc(8'h18, 32'h0);
    ev(16'h2000, 4'h0);
    pins(1'b1, 1'b0);
    rdc(8'h18, 32'h0);
    xfer(1'b0, 8'h19, 32'h21);
    rdc(8'h19, 32'h21);
    ev(16'h4000, 4'h0);
    pins(1'b0, 1'b0);
    rdc(8'h18, 32'h8800);
    rdc(8'h18, 32'h8000);
    pins(1'b1, 1'b0);
    ev(16'h0820, 4'h0);
    rdc(8'h18, 32'hC600);
    rdc(8'h18, 32'hC000);
    ev(16'h1000, 4'h0);
    ev(16'h0000, 4'h2);
    pins(1'b0, 1'b0);
    ev(16'h0000, 4'h1);
    pins(1'b1, 1'b0);
    rdc(8'h18, 32'h0);
    @(posedge ref_clk);
    clk_en <= 1'b0;
    ev(16'h1000, 4'h0);
    @(posedge ref_clk);
    clk_en <= 1'b1;
    pins(1'b1, 1'b0);
    rdc(8'h18, 32'h0);
    xfer(1'b0, 8'h28, 32'h4);
    ev(16'h0005, 4'h0);
    pins(1'b0, 1'b0);
    rdc(8'h18, 32'h0042);
    ev(16'h0000, 4'h4);
    rdc(8'h18, 32'h0);
    xfer(1'b0, 8'h28, 32'h6);
    ev(16'h0008, 4'h0);
    rdc(8'h18, 32'h0041);
    ev(16'h0000, 4'h8);
    xfer(1'b0, 8'h28, 32'h19);
    ev(16'h0001, 4'h0);
    ev(16'h0002, 4'h0);
    ev(16'h0004, 4'h0);
    pins(1'b1, 1'b0);
    rdc(8'h18, 32'h000E);
    ev(16'h0008, 4'h0);
    rdc(8'h18, 32'h004F);
    xfer(1'b0, 8'h24, 32'h3);
    pins(1'b1, 1'b1);
    rdc(8'h20, 32'h3);
    xfer(1'b0, 8'h20, 32'h3);
    pins(1'b1, 1'b0);
    rdc(8'h20, 32'h0);
    ev(16'h2000, 4'h0);
    pins(1'b0, 1'b1);
    xfer(1'b0, 8'h24, 32'h2);
    pins(1'b0, 1'b0);
    final_report;
  end
endmodule
